// ---- rtl/pcb_bus_if.sv ----
// pcb_bus_if: host bus between the bridge end and the host end
// each party gives a value and an active-low enable; the wire level is resolved here,
// undriven lines float to the pull-up level
`timescale 1ns/1ps
`default_nettype none
interface pcb_bus_if;
	logic [31:0] ad_h, ad_d, ad;
	logic        ad_h_oe_n, ad_d_oe_n;
	logic [3:0]  cbe_h, cbe;
	logic        cbe_h_oe_n;
	logic        par_h, par_h_oe_n, par_d, par_d_oe_n, par;
	logic        frame_h, irdy_h, hctl_oe_n, frame_n, irdy_n;
	logic        devsel_d, trdy_d, stop_d, dctl_oe_n, devsel_n, trdy_n, stop_n;
	logic        perr_d, perr_d_oe_n, perr_n;
	logic        serr_d_oe_n, serr_n;
	logic        idsel, req_n, gnt_n;

	// wire resolution with central pull-ups
	assign ad       = !ad_h_oe_n ? ad_h : (!ad_d_oe_n ? ad_d : '1);
	assign cbe      = !cbe_h_oe_n ? cbe_h : '1;
	assign par      = !par_h_oe_n ? par_h : (!par_d_oe_n ? par_d : 1'b1);
	assign frame_n  = !hctl_oe_n ? frame_h : 1'b1;
	assign irdy_n   = !hctl_oe_n ? irdy_h : 1'b1;
	assign devsel_n = !dctl_oe_n ? devsel_d : 1'b1;
	assign trdy_n   = !dctl_oe_n ? trdy_d : 1'b1;
	assign stop_n   = !dctl_oe_n ? stop_d : 1'b1;
	assign perr_n   = !perr_d_oe_n ? perr_d : 1'b1;
	assign serr_n   = serr_d_oe_n; // open drain: low only while enabled

	modport device (
		output ad_d, ad_d_oe_n, par_d, par_d_oe_n, devsel_d, trdy_d, stop_d, dctl_oe_n,
		output perr_d, perr_d_oe_n, serr_d_oe_n, req_n,
		input  ad, cbe, par, frame_n, irdy_n, idsel, gnt_n
	);
	modport host (
		output ad_h, ad_h_oe_n, cbe_h, cbe_h_oe_n, par_h, par_h_oe_n,
		output frame_h, irdy_h, hctl_oe_n, idsel, gnt_n,
		input  ad, par, devsel_n, trdy_n, stop_n, req_n
	);
endinterface : pcb_bus_if
`default_nettype wire

// ---- rtl/pcb_card_bridge.sv ----
// pcb_card_bridge: bridge end; host bus target, two-entry write buffer, card bus
// initiator, card arbiter, card clock with clock-run, card reset, interrupt and audio
// assumes card-side inputs are synchronous to ref_clk_i and the host end obeys the bus
//
// Functional notes
// - drive sustained lines high before releasing them
// - start driving only after previous owner released
// - host bus sampled and driven on clock rise
// - reset clears everything, sockets powered down
// - first clock address, following clocks data
// - command in address phase, then byte enables
// - even parity, one clock late, by driver
// - frame starts transaction, drops before last phase
// - word moves only when both readies asserted
// - claim with device select; watch it as initiator
// - target stop request ends the transaction
// - configuration answered only with idsel asserted
// - data parity on perr, address parity on serr
// - request host bus for card masters; grant returns
// - divided card clock, stoppable low; async card reset
// - drive clock-run low while clock runs
// - card bus multiplexed with delayed even parity
// - card bus handshake as on host bus
// - card lock line never driven
// - only one card granted at a time
// - card interrupt is level, pending while held
// - card audio passed to speaker pin
`timescale 1ns/1ps
`default_nettype none
module pcb_card_bridge (
	input  wire logic                      ref_clk_i,
	input  wire logic                      rst_n_i,
	pcb_bus_if.device                      bus,
	input  wire logic                      io_space_en_i,
	input  wire logic                      mem_space_en_i,
	input  wire logic                      parity_resp_en_i,
	input  wire logic                      serr_en_i,
	input  wire logic [pcb_pkg::AD_W-1:0]  read_word_i,
	output logic      [pcb_pkg::AD_W-1:0]  read_addr_o,
	output logic                           read_cfg_o,
	output logic                           read_strobe_o,
	output logic                           data_parity_err_o,
	output logic                           sys_err_o,
	output logic                           card_abort_o,
	output logic      [pcb_pkg::AD_W-1:0]  card_ad_o,
	output logic                           card_ad_oe_n_o,
	output logic      [pcb_pkg::BE_W-1:0]  card_cbe_o,
	output logic                           card_par_o,
	output logic                           card_par_oe_n_o,
	output logic                           card_frame_n_o,
	output logic                           card_irdy_n_o,
	output logic                           card_ctl_oe_n_o,
	input  wire logic                      card_devsel_n_i,
	input  wire logic                      card_trdy_n_i,
	input  wire logic                      card_stop_n_i,
	output logic                           card_lock_line_o,
	output logic                           card_lock_line_oe_n_o,
	input  wire logic [1:0]                card_req_n_i,
	output logic      [1:0]                card_grant_n_o,
	output logic                           card_clock_o,
	input  wire logic                      clk_stop_req_i,
	input  wire logic                      card_clock_run_i,
	output logic                           card_clock_run_o,
	output logic                           card_clock_run_oe_n_o,
	input  wire logic                      card_reset_req_i,
	output logic                           card_reset_out_n_o,
	input  wire logic [1:0]                card_int_n_i,
	output logic      [1:0]                card_irq_pending_o,
	input  wire logic                      card_audio_i,
	output logic                           speaker_output_pin_o,
	input  wire logic                      socket_power_on_i,
	output logic                           socket_power_o
);
	import pcb_pkg::*;

	typedef enum logic [1:0] {T_IDLE, T_CLAIM, T_DATA, T_TURN} pcb_tgt_e;
	typedef enum logic [1:0] {C_IDLE, C_ADDR, C_DATA, C_TURN} pcb_cst_e;

	// active-low pins are kept as "asserted" flags so that all of reset is zero
	typedef struct packed {
		pcb_tgt_e         tgt;
		logic             wr;
		logic             cfg;
		logic [31:0]      taddr;
		logic             fr_a;
		logic             apchk;
		logic             dpchk;
		logic [31:0]      chk_ad;
		logic [3:0]       chk_cbe;
		logic [31:0]      ad;
		logic             ad_oe;
		logic             par;
		logic             par_oe;
		logic             devsel;
		logic             trdy;
		logic             stop;
		logic             ctl_oe;
		logic             perr;
		logic             perr_oe;
		logic             serr_oe;
		logic             dpe;
		logic             sse;
		logic             rd_stb;
		pcb_entry_s [1:0] fifo;
		logic             wp;
		logic             rp;
		logic [1:0]       cnt;
		pcb_cst_e         cst;
		logic [2:0]       wait_cnt;
		logic             abort;
		logic [31:0]      cad;
		logic [3:0]       ccbe;
		logic             cad_oe;
		logic             cpar;
		logic             cpar_oe;
		logic             cframe;
		logic             cirdy;
		logic             cctl_oe;
		logic [1:0]       div;
		logic             run;
		logic [1:0]       cgnt;
		logic             last;
		logic             hreq;
		logic [1:0]       irq;
		logic             audio;
		logic             power;
		logic             card_reset_out;
	} pcb_dev_s;

	pcb_dev_s   p;
	pcb_dev_s   next_p;
	logic       addr_ph;
	logic       xfer;
	logic       tick;
	logic       room;
	logic [1:0] req;
	pcb_entry_s head;

	// commands this end answers; configuration needs its select line
	function automatic logic pcb_hit(input logic [3:0] c, input logic sel,
	                                 input logic io_en, input logic mem_en);
		case (c)
			CMD_IO_RD, CMD_IO_WR: return io_en;
			CMD_MEM_RD, CMD_MEM_WR, CMD_MEM_RDM, CMD_MEM_RDL: return mem_en;
			CMD_CFG_RD, CMD_CFG_WR: return sel;
			default: return 1'b0;
		endcase
	endfunction : pcb_hit

	// decoded events of the current cycle
	assign addr_ph = !bus.frame_n && !p.fr_a;                 // first clock of frame
	assign xfer    = (p.tgt == T_DATA) && p.trdy && !bus.irdy_n;
	assign tick    = p.run && (p.div == '0);
	assign room    = (p.cnt != BUF_DEPTH);
	assign req     = ~card_req_n_i;
	assign head    = p.fifo[p.rp];

	// next-state logic for the whole end
	always_comb begin
		logic push;
		logic pop;
		push = 1'b0;
		pop = 1'b0;
		next_p = p;
		next_p.fr_a = !bus.frame_n;
		next_p.rd_stb = 1'b0;
		next_p.dpe = 1'b0;
		next_p.sse = 1'b0;
		next_p.abort = 1'b0;
		next_p.apchk = 1'b0;
		next_p.dpchk = 1'b0;
		next_p.serr_oe = 1'b0;
		// read data parity follows the data by one clock
		next_p.par = pcb_even_par(p.ad, bus.cbe);
		next_p.par_oe = p.ad_oe;

		// address parity goes to the open-drain system error line
		if (p.apchk && (bus.par != pcb_even_par(p.chk_ad, p.chk_cbe))) begin
			next_p.sse = 1'b1;
			next_p.serr_oe = serr_en_i;
		end
		// write data parity error; perr is parked high one clock before release
		if (p.dpchk && (bus.par != pcb_even_par(p.chk_ad, p.chk_cbe))) begin
			next_p.dpe = 1'b1;
			next_p.perr = parity_resp_en_i;
		end else if (p.perr) begin
			next_p.perr = 1'b0;
		end else if (p.tgt == T_IDLE) begin
			next_p.perr_oe = 1'b0;
		end

		// host bus target
		case (p.tgt)
			T_IDLE: begin
				if (addr_ph && pcb_hit(bus.cbe, bus.idsel, io_space_en_i, mem_space_en_i)) begin
					next_p.tgt = T_CLAIM;
					next_p.wr = bus.cbe[0]; // command in the address phase
					next_p.cfg = (bus.cbe == CMD_CFG_RD) || (bus.cbe == CMD_CFG_WR);
					next_p.taddr = bus.ad;
					next_p.apchk = 1'b1;
					next_p.chk_ad = bus.ad;
					next_p.chk_cbe = bus.cbe;
					// lines come up at inactive level a clock after the address
					next_p.ctl_oe = 1'b1;
					next_p.perr_oe = 1'b1;
				end
			end
			T_CLAIM: begin
				next_p.tgt = T_DATA;
				next_p.devsel = 1'b1; // medium-speed claim
			end
			T_DATA: begin
				if (xfer) begin
					next_p.taddr = p.taddr + ADDR_STEP;
					next_p.trdy = 1'b0;
					if (p.wr) begin
						push = !p.cfg; // configuration space holds nothing to forward
						next_p.chk_ad = bus.ad;
						next_p.chk_cbe = bus.cbe; // byte enables in data phase
						next_p.dpchk = 1'b1;
					end
				end
				if ((xfer || p.stop) && bus.frame_n) begin
					// frame already high: this was the last phase
					next_p.tgt = T_TURN;
					next_p.devsel = 1'b0;
					next_p.trdy = 1'b0;
					next_p.stop = 1'b0;
					next_p.ad_oe = 1'b0;
				end else if (!xfer && !p.trdy && !p.stop) begin
					if (p.wr) begin
						// a full buffer turns into a stop rather than a lost word
						next_p.trdy = room;
						next_p.stop = !room;
					end else begin
						next_p.ad = read_word_i;
						next_p.ad_oe = 1'b1;
						next_p.trdy = 1'b1; // read data valid with trdy
						next_p.rd_stb = 1'b1;
					end
				end
			end
			T_TURN: begin
				next_p.tgt = T_IDLE;
				next_p.ctl_oe = 1'b0; // released after one inactive clock
			end
			default: next_p.tgt = T_IDLE;
		endcase

		// card clock divider; stopping waits for an idle card side
		next_p.div = (p.div == CARD_DIV_LAST) ? '0 : p.div + 2'h1;
		if (!p.run) begin
			next_p.div = '0;
			if (!clk_stop_req_i || !card_clock_run_i || (p.cnt != '0)) begin
				next_p.run = 1'b1; // stop request gone, card pulled clock-run low or words buffered
			end
		end else if (tick && clk_stop_req_i && (p.cst == C_IDLE) && (p.cnt == '0)
		             && (p.cgnt == '0)) begin
			next_p.run = 1'b0;
		end

		// card side moves once per card clock
		if (tick) begin
			next_p.cpar = pcb_even_par(p.cad, p.ccbe);
			next_p.cpar_oe = p.cad_oe;
			case (p.cst)
				C_IDLE: begin
					if ((p.cnt != '0) && (p.cgnt == '0)) begin
						next_p.cst = C_ADDR;
						next_p.cctl_oe = 1'b1;
						next_p.cframe = 1'b1;
						next_p.cad = head.addr;
						next_p.ccbe = CMD_MEM_WR;
						next_p.cad_oe = 1'b1;
					end
				end
				C_ADDR: begin
					next_p.cst = C_DATA;
					next_p.cframe = 1'b0; // single data phase
					next_p.cirdy = 1'b1;
					next_p.cad = head.data;
					next_p.ccbe = head.be;
					next_p.wait_cnt = '0;
				end
				C_DATA: begin
					next_p.wait_cnt = p.wait_cnt + 3'h1;
					if (!card_devsel_n_i && !card_trdy_n_i) begin
						pop = 1'b1;
					end else if (card_devsel_n_i && (p.wait_cnt == ABORT_WAIT)) begin
						pop = 1'b1; // nobody claimed: word dropped
						next_p.abort = 1'b1;
					end
					if (pop || !card_stop_n_i) begin
						// a stop without trdy leaves the word for a retry
						next_p.cst = C_TURN;
						next_p.cirdy = 1'b0;
						next_p.cad_oe = 1'b0;
					end
				end
				C_TURN: begin
					next_p.cst = C_IDLE;
					next_p.cctl_oe = 1'b0;
				end
				default: next_p.cst = C_IDLE;
			endcase

			// card arbiter: a grant holds while its card keeps asking
			if (p.cgnt != '0) begin
				if ((p.cgnt & req) == '0) begin
					next_p.cgnt = '0;
				end
			end else if ((p.cst == C_IDLE) && (p.cnt == '0) && (req != '0)) begin
				next_p.cgnt = (req == 2'h3) ? (p.last ? 2'h1 : 2'h2) : req;
				next_p.last = (req == 2'h3) ? !p.last : req[1];
			end
			next_p.hreq = (req != '0);
		end

		// buffer bookkeeping
		if (push) begin
			next_p.fifo[p.wp] = '{addr: p.taddr, data: bus.ad, be: bus.cbe};
			next_p.wp = !p.wp;
		end
		if (pop) begin
			next_p.rp = !p.rp;
		end
		next_p.cnt = p.cnt + {1'b0, push} - {1'b0, pop};

		// side pins sampled each clock
		next_p.irq = ~card_int_n_i;
		next_p.audio = card_audio_i;
		next_p.power = socket_power_on_i;
		next_p.card_reset_out = card_reset_req_i;
	end

	// one register for all state; reset clears it to power-down
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			p <= '0;
		end else begin
			p <= next_p;
		end
	end

	// host bus pins
	assign bus.ad_d        = p.ad;
	assign bus.ad_d_oe_n   = !p.ad_oe;
	assign bus.par_d       = p.par;
	assign bus.par_d_oe_n  = !p.par_oe;
	assign bus.devsel_d    = !p.devsel;
	assign bus.trdy_d      = !p.trdy;
	assign bus.stop_d      = !p.stop;
	assign bus.dctl_oe_n   = !p.ctl_oe;
	assign bus.perr_d      = !p.perr;
	assign bus.perr_d_oe_n = !p.perr_oe;
	assign bus.serr_d_oe_n = !p.serr_oe;
	assign bus.req_n       = !p.hreq;

	// user side and card pins
	assign read_addr_o           = p.taddr;
	assign read_cfg_o            = p.cfg;
	assign read_strobe_o         = p.rd_stb;
	assign data_parity_err_o     = p.dpe;
	assign sys_err_o             = p.sse;
	assign card_abort_o          = p.abort;
	assign card_ad_o             = p.cad;
	assign card_ad_oe_n_o        = !p.cad_oe;
	assign card_cbe_o            = p.ccbe;
	assign card_par_o            = p.cpar;
	assign card_par_oe_n_o       = !p.cpar_oe;
	assign card_frame_n_o        = !p.cframe;
	assign card_irdy_n_o         = !p.cirdy;
	assign card_ctl_oe_n_o       = !p.cctl_oe;
	assign card_lock_line_o      = 1'b1;
	assign card_lock_line_oe_n_o = 1'b1; // lock not supported
	// a card owns the card bus only while the host has granted this end
	assign card_grant_n_o        = ~(p.cgnt & {2{!bus.gnt_n}});
	assign card_clock_o          = p.run && (p.div < CARD_CLK_HIGH);
	assign card_clock_run_o      = 1'b0;
	assign card_clock_run_oe_n_o = !p.run;
	// card reset follows the system reset without waiting for any clock
	assign card_reset_out_n_o    = rst_n_i && !p.card_reset_out;
	assign card_irq_pending_o    = p.irq;
	assign speaker_output_pin_o  = p.audio;
	assign socket_power_o        = p.power;
endmodule : pcb_card_bridge
`default_nettype wire

// ---- rtl/pcb_host_end.sv ----
// pcb_host_end: host bus initiator issuing single-phase transactions, plus the
// arbiter that grants the bus to the bridge end on request
// assumes commands are held stable while cmd_valid_i waits for cmd_ready_o
`timescale 1ns/1ps
`default_nettype none
module pcb_host_end (
	input  wire logic                      ref_clk_i,
	input  wire logic                      rst_n_i,
	pcb_bus_if.host                        bus,
	input  wire logic                      cmd_valid_i,
	output logic                           cmd_ready_o,
	input  wire logic [3:0]                cmd_code_i,
	input  wire logic [pcb_pkg::AD_W-1:0]  cmd_addr_i,
	input  wire logic [pcb_pkg::AD_W-1:0]  cmd_data_i,
	input  wire logic [pcb_pkg::BE_W-1:0]  cmd_be_i,
	input  wire logic                      cmd_cfg_i,
	output logic                           rsp_valid_o,
	output logic      [pcb_pkg::AD_W-1:0]  rsp_data_o,
	output logic      [1:0]                rsp_status_o
);
	import pcb_pkg::*;

	typedef enum logic [1:0] {H_IDLE, H_ADDR, H_DATA, H_TURN} pcb_hst_e;

	typedef struct packed {
		pcb_hst_e    hst;
		logic [31:0] ad;
		logic        ad_oe;
		logic [3:0]  cbe;
		logic        par;
		logic        par_oe;
		logic        frame;
		logic        irdy;
		logic        ctl_oe;
		logic        idsel;
		logic        gnt;
		logic        wr;
		logic [31:0] wdat;
		logic [3:0]  be;
		logic [2:0]  wcnt;
		logic [31:0] rdat;
		logic [3:0]  rcbe;
		logic        chk;
		logic [1:0]  stat;
		logic        rsp_v;
	} pcb_hst_s;

	pcb_hst_s p;
	pcb_hst_s next_p;
	logic     start;

	// no new command while the bridge end holds or asks for the bus
	assign cmd_ready_o = (p.hst == H_IDLE) && !p.gnt && bus.req_n;
	assign start       = cmd_valid_i && cmd_ready_o;

	// next-state logic
	always_comb begin
		next_p = p;
		next_p.rsp_v = 1'b0;
		next_p.par = pcb_even_par(p.ad, p.cbe); // one clock after the phase
		next_p.par_oe = p.ad_oe;
		next_p.gnt = !bus.req_n && (p.hst == H_IDLE) && !start;
		case (p.hst)
			H_IDLE: begin
				if (start) begin
					next_p.hst = H_ADDR;
					next_p.ctl_oe = 1'b1; // own turnaround already done
					next_p.frame = 1'b1;
					next_p.ad = cmd_addr_i;
					next_p.ad_oe = 1'b1;
					next_p.cbe = cmd_code_i;
					next_p.idsel = cmd_cfg_i;
					next_p.wr = cmd_code_i[0];
					next_p.wdat = cmd_data_i;
					next_p.be = cmd_be_i;
				end
			end
			H_ADDR: begin
				next_p.hst = H_DATA;
				next_p.frame = 1'b0; // next phase is the last
				next_p.irdy = 1'b1;
				next_p.cbe = p.be;
				next_p.idsel = 1'b0;
				next_p.ad = p.wdat;
				next_p.ad_oe = p.wr; // reads hand the lines to the target
				next_p.wcnt = '0;
				next_p.chk = 1'b0;
			end
			H_DATA: begin
				next_p.wcnt = p.wcnt + 3'h1;
				if (!bus.devsel_n && !bus.trdy_n) begin
					next_p.hst = H_TURN;
					next_p.rdat = bus.ad;
					next_p.rcbe = p.cbe;
					next_p.chk = !p.wr;
					next_p.stat = RSP_OK;
				end else if (!bus.stop_n) begin
					next_p.hst = H_TURN;
					next_p.stat = RSP_RETRY;
				end else if (bus.devsel_n && (p.wcnt == ABORT_WAIT)) begin
					next_p.hst = H_TURN; // no target answered
					next_p.stat = RSP_ABORT;
				end
				if (next_p.hst == H_TURN) begin
					next_p.irdy = 1'b0;
					next_p.ad_oe = 1'b0;
				end
			end
			H_TURN: begin
				next_p.hst = H_IDLE;
				next_p.ctl_oe = 1'b0; // lines were high for this clock
				next_p.rsp_v = 1'b1;
				if (p.chk && (bus.par != pcb_even_par(p.rdat, p.rcbe))) begin
					next_p.stat = RSP_PERR;
				end
			end
			default: next_p.hst = H_IDLE;
		endcase
	end

	// all state in one register
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			p <= '0;
		end else begin
			p <= next_p;
		end
	end

	// bus and user outputs
	assign bus.ad_h       = p.ad;
	assign bus.ad_h_oe_n  = !p.ad_oe;
	assign bus.cbe_h      = p.cbe;
	assign bus.cbe_h_oe_n = !p.ctl_oe;
	assign bus.par_h      = p.par;
	assign bus.par_h_oe_n = !p.par_oe;
	assign bus.frame_h    = !p.frame;
	assign bus.irdy_h     = !p.irdy;
	assign bus.hctl_oe_n  = !p.ctl_oe;
	assign bus.idsel      = p.idsel;
	assign bus.gnt_n      = !p.gnt;
	assign rsp_valid_o    = p.rsp_v;
	assign rsp_data_o     = p.rdat;
	assign rsp_status_o   = p.stat;
endmodule : pcb_host_end
`default_nettype wire

// ---- rtl/pcb_pkg.sv ----
// pcb_pkg: shared constants, bus command codes, buffer entry layout and parity
// assumes one 100 MHz system clock shared by both ends of the host bus
package pcb_pkg;
	localparam int unsigned SYS_CLK_HZ  = 100_000_000;
	localparam int unsigned CARD_CLK_HZ = 33_000_000;
	// card clock period rounds up so the card never sees more than its top rate
	localparam int unsigned CARD_DIV    = (SYS_CLK_HZ + CARD_CLK_HZ - 1) / CARD_CLK_HZ;
	localparam logic [1:0]  CARD_DIV_LAST = 2'(CARD_DIV - 1);
	localparam logic [1:0]  CARD_CLK_HIGH = 2'(CARD_DIV / 2);
	localparam int unsigned AD_W        = 32;
	localparam int unsigned BE_W        = 4;
	localparam logic [1:0]  BUF_DEPTH   = 2'h2;
	localparam logic [31:0] ADDR_STEP   = 32'h4;
	// clocks without device select before an initiator gives up
	localparam logic [2:0]  ABORT_WAIT  = 3'h5;
	localparam logic [3:0]  CMD_IO_RD   = 4'h2;
	localparam logic [3:0]  CMD_IO_WR   = 4'h3;
	localparam logic [3:0]  CMD_MEM_RD  = 4'h6;
	localparam logic [3:0]  CMD_MEM_WR  = 4'h7;
	localparam logic [3:0]  CMD_CFG_RD  = 4'ha;
	localparam logic [3:0]  CMD_CFG_WR  = 4'hb;
	localparam logic [3:0]  CMD_MEM_RDM = 4'hc;
	localparam logic [3:0]  CMD_MEM_RDL = 4'he;
	localparam logic [1:0]  RSP_OK      = 2'h0;
	localparam logic [1:0]  RSP_RETRY   = 2'h1;
	localparam logic [1:0]  RSP_ABORT   = 2'h2;
	localparam logic [1:0]  RSP_PERR    = 2'h3;

	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] data;
		logic [3:0]  be;
	} pcb_entry_s;

	// even parity bit over address/data and command/byte enables
	function automatic logic pcb_even_par(input logic [31:0] a, input logic [3:0] c);
		return ^{a, c};
	endfunction : pcb_even_par
endpackage : pcb_pkg

// ---- verif/pcb_bus_props.sv ----
// pcb_bus_props: timing rules checked on the resolved host bus wires
// assumes one clock domain and the interface's pull-up resolution
`timescale 1ns/1ps
`default_nettype none
module pcb_bus_props (
	input wire logic        ref_clk_i,
	input wire logic        rst_n_i,
	input wire logic [31:0] ad,
	input wire logic [3:0]  cbe,
	input wire logic        par,
	input wire logic        frame_n,
	input wire logic        irdy_n,
	input wire logic        devsel_n,
	input wire logic        trdy_n,
	input wire logic        dctl_oe_n,
	input wire logic        ad_h_oe_n,
	input wire logic        ad_d_oe_n
);
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_n_i);
	// parity lags its phase by one clock; a turnaround needs one released cycle
	property p_apar; $fell(frame_n) |=> par == ^{$past(ad), $past(cbe)}; endproperty
	a_apar: assert property (p_apar) else $error("address parity wrong");
	property p_dpar; !irdy_n && !trdy_n |=> par == ^{$past(ad), $past(cbe)}; endproperty
	a_dpar: assert property (p_dpar) else $error("data parity wrong");
	property p_trel; $rose(dctl_oe_n) |-> $past(devsel_n) && $past(trdy_n); endproperty
	a_trel: assert property (p_trel) else $error("target released while low");
	property p_dturn; $fell(ad_d_oe_n) |-> $past(ad_h_oe_n); endproperty
	a_dturn: assert property (p_dturn) else $error("bridge drove ad too soon");
	property p_hturn; $fell(ad_h_oe_n) |-> $past(ad_d_oe_n); endproperty
	a_hturn: assert property (p_hturn) else $error("host drove ad too soon");
	property p_sel; $fell(devsel_n) |-> !$past(frame_n, 2) && $past(frame_n, 3); endproperty
	a_sel: assert property (p_sel) else $error("devsel timing wrong");
	property p_rdy; !trdy_n |-> !devsel_n && !irdy_n; endproperty
	a_rdy: assert property (p_rdy) else $error("trdy without devsel or irdy");
	property p_one; $fell(frame_n) |=> frame_n && !irdy_n; endproperty
	a_one: assert property (p_one) else $error("frame not ended for last phase");
endmodule : pcb_bus_props
`default_nettype wire

// ---- verif/pci_cardbus_bus_signaling_tb.sv ----
// pci_cardbus_bus_signaling_tb: host end and bridge end on one bus
// assumes a toy card target that answers at once unless hold stalls it
`timescale 1ns/1ps
`default_nettype none
module pci_cardbus_bus_signaling_tb;
	import pcb_pkg::*;
	logic        ref_clk_i, rst_n_i, io_space_en_i, mem_space_en_i, hold, card_audio_i;
	logic        cmd_valid_i, cmd_ready_o, cmd_cfg_i, rsp_valid_o, socket_power_on_i;
	logic        read_cfg_o, read_strobe_o, data_parity_err_o, sys_err_o, card_abort_o;
	logic        card_ad_oe_n_o, card_par_o, card_par_oe_n_o, card_frame_n_o, card_irdy_n_o;
	logic        card_ctl_oe_n_o, card_lock_line_o, card_lock_line_oe_n_o, card_clock_o;
	logic        card_clock_run_i, card_clock_run_o, card_clock_run_oe_n_o, card_reset_out_n_o;
	logic        speaker_output_pin_o, socket_power_o;
	logic [3:0]  cmd_code_i, cmd_be_i, card_cbe_o;
	logic [31:0] cmd_addr_i, cmd_data_i, rsp_data_o, read_word_i, read_addr_o, card_ad_o;
	logic [1:0]  rsp_status_o, card_req_n_i, card_grant_n_o, card_int_n_i, card_irq_pending_o;
	int          failures = 0;
	int          tests_run = 0;
	pcb_bus_if bus_if ();
	// clock-run pin pulled up; card devsel follows irdy, trdy also waits for hold
	assign card_clock_run_i = card_clock_run_oe_n_o | card_clock_run_o;
	pcb_card_bridge u_pcb_card_bridge (.*, .bus(bus_if.device), .parity_resp_en_i(1'b1),
		.serr_en_i(1'b1), .card_devsel_n_i(card_irdy_n_o), .card_trdy_n_i(card_irdy_n_o | hold),
		.card_stop_n_i(1'b1), .clk_stop_req_i(1'b0), .card_reset_req_i(1'b0));
	pcb_host_end u_pcb_host_end (.*, .bus(bus_if.host));
	pcb_bus_props u_pcb_bus_props (.ref_clk_i, .rst_n_i, .ad(bus_if.ad), .cbe(bus_if.cbe),
		.par(bus_if.par), .frame_n(bus_if.frame_n), .irdy_n(bus_if.irdy_n),
		.devsel_n(bus_if.devsel_n), .trdy_n(bus_if.trdy_n), .dctl_oe_n(bus_if.dctl_oe_n),
		.ad_h_oe_n(bus_if.ad_h_oe_n), .ad_d_oe_n(bus_if.ad_d_oe_n));
	// compare, count and report at once
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			failures++;
			$display("[ERR] %s exp %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic final_report();
		if (failures == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : final_report
	// one host command, held until taken, then wait for its response
	task automatic cmd(input logic [3:0] c, input logic [31:0] a, input logic cfg);
		@(negedge ref_clk_i);
		{cmd_valid_i, cmd_code_i, cmd_addr_i, cmd_cfg_i} = {1'b1, c, a, cfg};
		while (cmd_ready_o !== 1'b1) @(negedge ref_clk_i);
		@(negedge ref_clk_i);
		cmd_valid_i = 1'b0;
		while (rsp_valid_o !== 1'b1) @(negedge ref_clk_i);
	endtask : cmd
	// read returns the offered word
	task automatic t_read();
		read_word_i = 32'h5a3c_0ff1;
		cmd(CMD_MEM_RD, 32'h0000_1040, 1'b0);
		chk("rd data", rsp_data_o, 32'h5a3c_0ff1);
		chk("rd addr", read_addr_o, 32'h0000_1044);
	endtask : t_read
	// decode: config needs idsel, io its enable
	task automatic t_decode();
		logic [3:0] c [6] = '{CMD_IO_RD, CMD_CFG_RD, CMD_CFG_RD, CMD_CFG_WR, CMD_MEM_RDL, CMD_IO_WR};
		for (int i = 0; i < 6; i++) begin
			io_space_en_i = (i == 5);
			cmd(c[i], 32'h0000_2000, i inside {2, 3});
			chk("status", 32'(rsp_status_o), 32'((i < 2) ? RSP_ABORT : RSP_OK));
			chk("cfg", 32'(read_cfg_o), 32'(i inside {2, 3}));
		end
		cmd(CMD_MEM_RDM, 32'h0000_2000, 1'b0);
		chk("rdm status", 32'(rsp_status_o), 32'(RSP_OK));
	endtask : t_decode
	// a host write reaches the card as address phase, then data phase
	task automatic t_write();
		cmd(CMD_MEM_WR, 32'h0000_3008, 1'b0);
		while (card_frame_n_o !== 1'b0) @(negedge ref_clk_i);
		chk("card addr", {card_cbe_o, card_ad_o[27:0]}, {CMD_MEM_WR, 28'h000_3008});
		while (card_irdy_n_o !== 1'b0) @(negedge ref_clk_i);
		chk("card data", {card_cbe_o, card_ad_o[27:0]}, 32'h5001_d00d);
	endtask : t_write
	// side pins; both cards ask, one is granted
	task automatic t_side();
		{card_audio_i, card_int_n_i, card_req_n_i} = 5'h10;
		repeat (40) @(negedge ref_clk_i);
		chk("audio irq", 32'({speaker_output_pin_o, card_irq_pending_o}), 32'h7);
		chk("lock clkrun", 32'({card_lock_line_oe_n_o, card_clock_run_oe_n_o}), 32'h2);
		chk("power rst", 32'({socket_power_o, card_reset_out_n_o}), 32'h3);
		chk("req grant", 32'({bus_if.req_n, ^card_grant_n_o}), 32'h1);
		card_req_n_i = 2'h3;
	endtask : t_side
	// stalled card: third write is stopped, later retried
	task automatic t_full();
		hold = 1'b1;
		for (int i = 0; i < 3; i++) begin
			cmd(CMD_MEM_WR, 32'h0000_4000, 1'b0);
			chk("fill", 32'(rsp_status_o), 32'((i == 2) ? RSP_RETRY : RSP_OK));
		end
		hold = 1'b0;
		for (int i = 0; i < 9 && rsp_status_o !== RSP_OK; i++) cmd(CMD_MEM_WR, 32'h0000_4000, 1'b0);
		chk("drain", 32'(rsp_status_o), 32'(RSP_OK));
	endtask : t_full
	initial begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	// reset three cycles, then run the scenarios
	initial begin
		{rst_n_i, hold, cmd_valid_i, cmd_code_i, cmd_addr_i, cmd_cfg_i, card_audio_i} = '0;
		{io_space_en_i, mem_space_en_i, read_word_i} = 34'h1_0000_0000;
		{cmd_data_i, cmd_be_i, card_req_n_i, card_int_n_i, socket_power_on_i} = {32'hc001_d00d, 9'h0bf};
		repeat (3) @(negedge ref_clk_i);
		chk("reset outs", 32'({card_reset_out_n_o, socket_power_o, card_clock_o}), 32'h0);
		rst_n_i = 1'b1;
		t_read();
		t_decode();
		t_write();
		t_side();
		t_full();
		final_report();
	end
	// hang guard
	initial begin
		repeat (20000) @(posedge ref_clk_i);
		failures++;
		final_report();
	end
endmodule : pci_cardbus_bus_signaling_tb
`default_nettype wire
